/* ldr_chan.sv */
`timescale 1ns/100ps
module ldr_chan
  import ldr_pkg::*;
#(
  parameter int FAULT_CNT = FAULT_CYC
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Diagnostics
  input  wire logic                 fault_level,
  input  wire logic                 diag_win,
  output logic                      fault_hit,
  // Dimming
  input  wire logic [7:0]           dim_reg,
  input  wire logic [DUTY_BITS-1:0] duty_cnt,
  output logic                      pwm_on
);

  localparam int CNT_W = $clog2(FAULT_CNT + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(FAULT_CNT);

  logic [CNT_W-1:0] persist_q;

  // ----------------------------------------------------------------
  // Fault persistence filter
  // ----------------------------------------------------------------
  // A short glitch restarts the count, so only a steady open load latches
  always_ff @(posedge clk) begin
    if (rst) begin
      persist_q <= '0;
    end else if (fault_level && diag_win) begin
      if (persist_q != CNT_MAX) begin
        persist_q <= persist_q + 1'b1;
      end
    end else begin
      persist_q <= '0;
    end
  end

  // Held while the fault stays, so a cleared flag sets again at once
  assign fault_hit = (persist_q == CNT_MAX);

  // Live register value, so a new gain acts mid-frame
  assign pwm_on = dim_reg[CH_ON_BIT] && (duty_cnt < dim_reg[DUTY_BITS-1:0]);

  AST_FAULT_AFTER_PERSIST: assert property (
    @(posedge clk) disable iff (rst)
    (fault_level && diag_win && persist_q == CNT_MAX - 1'b1) |=> fault_hit
  ) else $error("fault not latched after persistence time");

  AST_FAULT_NEEDS_WINDOW: assert property (
    @(posedge clk) disable iff (rst)
    !diag_win |=> !fault_hit
  ) else $error("fault latched outside diagnostic window");

  AST_FAULT_NOT_EARLY: assert property (
    @(posedge clk) disable iff (rst)
    $rose(fault_hit) |-> $past(diag_win, 1) && $past(fault_level && diag_win, FAULT_CNT)
  ) else $error("fault latched before persistence time");

endmodule : ldr_chan

/* ldr_host.sv */
`timescale 1ns/100ps
module ldr_host (
  // Clock
  input  wire logic       clk,
  // Request side
  output logic      [7:0] cmd,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  // Answer side
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  input  wire logic       wack,
  input  wire logic       err
);
  // ----------------------------------------------------------------
  // One access: strobe for one edge, answer one edge later
  // ----------------------------------------------------------------
  initial begin
    {cmd, addr, wdata, wr, rd} = '0;
  end

  // Idle fields show the inverse, so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] c, a, d,
                      output logic [7:0] q, output logic [2:0] ans);
    @(negedge clk);
    {cmd, addr, wdata, wr, rd} = {c, a, d, w, ~w};
    // Answer stands only for the cycle after the taking edge; catch it mid-cycle
    @(negedge clk);
    q   = rdata;
    ans = {rvalid, wack, err};
    {cmd, addr, wdata, wr, rd} = {~c, ~a, ~d, 2'b00};
  endtask : xfer
endmodule : ldr_host

/* ldr_pkg.sv */
package ldr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PWM_NOM_HZ    = 220;
  localparam int DUTY_BITS     = 7;
  localparam int DUTY_STEPS    = 1 << DUTY_BITS;
  // Cycles per duty step at the nominal rate; prescaler doubles it
  localparam int STEP_DIV      = CLK_HZ / (PWM_NOM_HZ * DUTY_STEPS);
  localparam int PRESC_FACTOR  = 2;
  localparam int FAULT_NS      = 10_000;
  localparam int FAULT_CYC     = (FAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FAULT_HI  = 8'h03;
  localparam logic [7:0] ADDR_FAULT_LO  = 8'h04;
  localparam logic [7:0] ADDR_DIM_FIRST = 8'h05;
  localparam logic [7:0] ADDR_DIM_LAST  = 8'h10;
  localparam logic [7:0] ADDR_PAT_HI    = 8'h20;
  localparam logic [7:0] ADDR_PAT_A_LO  = 8'h21;
  localparam logic [7:0] ADDR_PAT_B_LO  = 8'h22;
  localparam logic [7:0] ADDR_VERSION   = 8'h24;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DIM_A      = 8'h01;
  localparam logic [7:0] CMD_DIM_B      = 8'h02;
  localparam logic [7:0] CMD_FAULT_DIR  = 8'h03;
  localparam logic [7:0] CMD_FAULT_A    = 8'h09;
  localparam logic [7:0] CMD_FAULT_B    = 8'h0A;
  localparam logic [7:0] CMD_PAT_A      = 8'h20;
  localparam logic [7:0] CMD_PAT_B      = 8'h21;
  localparam logic [7:0] CMD_PAT_VER    = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PRESC_BIT   = 7;
  localparam int HI_CH_LSB   = 8;
  localparam int HI_CH_W     = 4;
  localparam int LO_CH_W     = 8;
  localparam int CH_ON_BIT   = 7;
  localparam int PAT_B_LSB   = 4;

  // Kind of access decoded from one request
  typedef enum {REQ_IDLE, REQ_READ, REQ_WRITE, REQ_REFUSE} ldr_req_e;

endpackage : ldr_pkg

/* ldr_regs.sv */
`timescale 1ns/100ps
module ldr_regs
  import ldr_pkg::*;
#(
  parameter int         NUM_CH    = 12,
  parameter int         FAULT_CNT = FAULT_CYC,
  parameter logic [4:0] PART_TYPE = 5'h15, // Arbitrary value
  parameter logic [2:0] REVISION  = 3'h2   // Arbitrary value
) (
  // Clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  // Register access from the message decoder
  input  wire logic [7:0]        REG_CMD,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [7:0]        REG_RDATA,
  output logic                   REG_RVALID,
  output logic                   REG_WACK,
  output logic                   REG_ERR,
  // Pins and analog sense
  input  wire logic              STANDALONE_MODE,
  input  wire logic              PATTERN_SELECT_PIN,
  input  wire logic              POWER_GOOD,
  input  wire logic [NUM_CH-1:0] OPEN_FAULT,
  // Channel control
  output logic      [NUM_CH-1:0] CH_DRIVE,
  output logic                   DIAG_WINDOW
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The register map has room for exactly twelve channels
  if (NUM_CH != HI_CH_LSB + HI_CH_W) begin : g_bad_num_ch
    $error("NUM_CH must be 12");
  end
  if (FAULT_CNT < 2) begin : g_bad_fault_cnt
    $error("FAULT_CNT must be at least 2");
  end

  localparam int PIN_W    = NUM_CH + 3;
  localparam int IDX_PWR  = NUM_CH;
  localparam int IDX_SEL  = NUM_CH + 1;
  localparam int IDX_SOLO = NUM_CH + 2;
  localparam int STEP_W  = $clog2(STEP_DIV * PRESC_FACTOR);
  localparam logic [STEP_W-1:0] STEP_NOM  = STEP_W'(STEP_DIV - 1);
  localparam logic [STEP_W-1:0] STEP_SLOW = STEP_W'(STEP_DIV * PRESC_FACTOR - 1);

  logic [PIN_W-1:0]     pin_meta_q;
  logic [PIN_W-1:0]     pin_mid_q;
  logic [PIN_W-1:0]     pin_late_q;
  logic [PIN_W-1:0]     pin_stable_q;
  logic                 presc_q;
  logic [7:0]           dim_q [NUM_CH];
  logic [NUM_CH-1:0]    pat_a_q;
  logic [NUM_CH-1:0]    pat_b_q;
  logic [NUM_CH-1:0]    fault_q;
  logic [NUM_CH-1:0]    hit_vec;
  logic [NUM_CH-1:0]    pwm_vec;
  logic [NUM_CH-1:0]    clr_mask;
  logic [STEP_W-1:0]    step_cnt_q;
  logic [DUTY_BITS-1:0] duty_cnt_q;
  logic                 step_en;
  logic                 legal;
  logic                 in_dim;
  logic [7:0]           dim_off;
  logic [3:0]           dim_idx;
  logic [7:0]           rd_val;
  ldr_req_e             req;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a bit moves on only once stages two and three agree
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pin_meta_q   <= '0;
      pin_mid_q    <= '0;
      pin_late_q   <= '0;
      pin_stable_q <= '0;
    end else begin
      pin_meta_q <= {STANDALONE_MODE, PATTERN_SELECT_PIN, POWER_GOOD, OPEN_FAULT};
      pin_mid_q  <= pin_meta_q;
      pin_late_q <= pin_mid_q;
      for (int i = 0; i < PIN_W; i++) begin
        if (pin_mid_q[i] == pin_late_q[i]) begin
          pin_stable_q[i] <= pin_late_q[i];
        end
      end
    end
  end

  // Window simply follows the filtered power-good level
  assign DIAG_WINDOW = pin_stable_q[IDX_PWR];

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  assign dim_off = REG_ADDR - ADDR_DIM_FIRST;
  assign dim_idx = dim_off[3:0];
  assign in_dim  = (REG_ADDR >= ADDR_DIM_FIRST) && (REG_ADDR <= ADDR_DIM_LAST);

  // Each register accepts only its own command codes
  always_comb begin
    legal = 1'b0;
    case (REG_ADDR)
      ADDR_FAULT_HI: legal = (REG_CMD == CMD_FAULT_A) || (REG_CMD == CMD_FAULT_B)
                             || (REG_CMD == CMD_FAULT_DIR);
      ADDR_FAULT_LO: legal = (REG_CMD == CMD_FAULT_A) || (REG_CMD == CMD_FAULT_B);
      ADDR_PAT_HI,
      ADDR_PAT_A_LO,
      ADDR_PAT_B_LO: legal = (REG_CMD == CMD_PAT_A) || (REG_CMD == CMD_PAT_B)
                             || (REG_CMD == CMD_PAT_VER);
      ADDR_VERSION:  legal = (REG_CMD == CMD_PAT_VER);
      default:       legal = in_dim && ((REG_CMD == CMD_DIM_A)
                                        || (REG_CMD == CMD_DIM_B));
    endcase
  end

  // A read wins if both strobes come together
  always_comb begin
    case ({REG_RD, REG_WR})
      2'b10,
      2'b11:   req = legal ? REQ_READ : REQ_REFUSE;
      2'b01:   req = legal ? REQ_WRITE : REQ_REFUSE;
      default: req = REQ_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Only bit 7 of the fault-high register is stored; the rest is dropped
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      presc_q <= 1'b0;
    end else if (req == REQ_WRITE && REG_ADDR == ADDR_FAULT_HI) begin
      presc_q <= REG_WDATA[PRESC_BIT];
    end
  end

  // Each write lands at once, so a burst may straddle a PWM frame
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      for (int i = 0; i < NUM_CH; i++) begin
        dim_q[i] <= REG_RESET;
      end
    end else if (req == REQ_WRITE && in_dim) begin
      dim_q[dim_idx] <= REG_WDATA;
    end
  end

  // Standalone on/off patterns
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pat_a_q <= '0;
      pat_b_q <= '0;
    end else if (req == REQ_WRITE) begin
      case (REG_ADDR)
        ADDR_PAT_HI: begin
          pat_b_q[NUM_CH-1:HI_CH_LSB] <= REG_WDATA[PAT_B_LSB+:HI_CH_W];
          pat_a_q[NUM_CH-1:HI_CH_LSB] <= REG_WDATA[HI_CH_W-1:0];
        end
        ADDR_PAT_A_LO: pat_a_q[LO_CH_W-1:0] <= REG_WDATA;
        ADDR_PAT_B_LO: pat_b_q[LO_CH_W-1:0] <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fault flags
  // ----------------------------------------------------------------
  // Reading a fault register clears only the channels it reports
  always_comb begin
    clr_mask = '0;
    if (req == REQ_READ && REG_ADDR == ADDR_FAULT_HI) begin
      clr_mask[NUM_CH-1:HI_CH_LSB] = '1;
    end
    if (req == REQ_READ && REG_ADDR == ADDR_FAULT_LO) begin
      clr_mask[LO_CH_W-1:0] = '1;
    end
  end

  // Set beats clear, so a fault caught during the read is kept
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      fault_q <= '0;
    end else begin
      fault_q <= (fault_q & ~clr_mask) | hit_vec;
    end
  end

  // ----------------------------------------------------------------
  // Read mux and answer
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = REG_RESET;
    case (REG_ADDR)
      ADDR_FAULT_HI: rd_val = {presc_q, 3'h0, fault_q[NUM_CH-1:HI_CH_LSB]};
      ADDR_FAULT_LO: rd_val = fault_q[LO_CH_W-1:0];
      ADDR_PAT_HI:   rd_val = {pat_b_q[NUM_CH-1:HI_CH_LSB], pat_a_q[NUM_CH-1:HI_CH_LSB]};
      ADDR_PAT_A_LO: rd_val = pat_a_q[LO_CH_W-1:0];
      ADDR_PAT_B_LO: rd_val = pat_b_q[LO_CH_W-1:0];
      ADDR_VERSION:  rd_val = {PART_TYPE, REVISION};
      default:       rd_val = in_dim ? dim_q[dim_idx] : REG_RESET;
    endcase
  end

  // One-cycle answer pulses, one cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      REG_RDATA  <= '0;
      REG_RVALID <= 1'b0;
      REG_WACK   <= 1'b0;
      REG_ERR    <= 1'b0;
    end else begin
      REG_RDATA  <= (req == REQ_READ) ? rd_val : REG_RESET;
      REG_RVALID <= (req == REQ_READ);
      REG_WACK   <= (req == REQ_WRITE);
      REG_ERR    <= (req == REQ_REFUSE);
    end
  end

  // ----------------------------------------------------------------
  // Dimming timebase
  // ----------------------------------------------------------------
  // Prescaler doubles the step length, halving the frame rate
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      step_cnt_q <= '0;
    end else if (step_cnt_q >= (presc_q ? STEP_SLOW : STEP_NOM)) begin
      step_cnt_q <= '0;
    end else begin
      step_cnt_q <= step_cnt_q + 1'b1;
    end
  end

  assign step_en = (step_cnt_q >= (presc_q ? STEP_SLOW : STEP_NOM));

  // Duty counter wraps once per dimming frame
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      duty_cnt_q <= '0;
    end else if (step_en) begin
      duty_cnt_q <= duty_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    ldr_chan #(
      .FAULT_CNT   (FAULT_CNT)
    ) u_chan (
      .clk         (SYS_CLK),
      .rst         (RST),
      .fault_level (pin_stable_q[c]),
      .diag_win    (pin_stable_q[IDX_PWR]),
      .fault_hit   (hit_vec[c]),
      .dim_reg     (dim_q[c]),
      .duty_cnt    (duty_cnt_q),
      .pwm_on      (pwm_vec[c])
    );
  end

  // Pattern bit 0 turns a channel on in standalone operation
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CH_DRIVE <= '0;
    end else if (pin_stable_q[IDX_SOLO]) begin
      CH_DRIVE <= pin_stable_q[IDX_SEL] ? ~pat_b_q : ~pat_a_q;
    end else begin
      CH_DRIVE <= pwm_vec;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [STEP_W:0] gap_q;
  logic            gap_ok_q;

  // Cycles since the last step; unreliable until a clean period passes
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      gap_q    <= '0;
      gap_ok_q <= 1'b0;
    end else if (step_en) begin
      gap_q    <= (STEP_W + 1)'(1);
      gap_ok_q <= 1'b1;
    end else begin
      gap_q    <= gap_q + 1'b1;
      if (presc_q != $past(presc_q)) begin
        gap_ok_q <= 1'b0;
      end
    end
  end

  AST_STEP_PERIOD: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (step_en && gap_ok_q && $past(step_en) == 1'b0 && $stable(presc_q))
      |-> gap_q == (presc_q ? STEP_SLOW + 1'b1 : STEP_NOM + 1'b1)
  ) else $error("duty step period wrong for prescaler setting");

  AST_FAULT_LO_CLEARED: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (req == REQ_READ && REG_ADDR == ADDR_FAULT_LO && hit_vec[LO_CH_W-1:0] == '0)
      |=> fault_q[LO_CH_W-1:0] == '0
  ) else $error("fault-low flags not cleared by read");

  AST_FAULT_WRITE_IGNORED: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (req == REQ_WRITE) |=> fault_q == ($past(fault_q) | $past(hit_vec))
  ) else $error("host write changed fault flags");

  AST_FAULT_HI_READ: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (req == REQ_READ && REG_ADDR == ADDR_FAULT_HI)
      |=> REG_RVALID && REG_RDATA == {$past(presc_q), 3'h0, $past(fault_q[NUM_CH-1:HI_CH_LSB])}
  ) else $error("fault-high read data wrong");

  AST_DIM_STORED: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (req == REQ_WRITE && in_dim) |=> dim_q[$past(dim_idx)] == $past(REG_WDATA)
  ) else $error("dimming write not stored");

  AST_BAD_CMD_REFUSED: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    ((REG_RD || REG_WR) && REG_ADDR == ADDR_FAULT_LO && REG_CMD == CMD_DIM_A)
      |=> REG_ERR && !REG_RVALID && !REG_WACK
  ) else $error("wrong command not refused");

  AST_VERSION_READ: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (req == REQ_READ && REG_ADDR == ADDR_VERSION) |=> REG_RDATA == {PART_TYPE, REVISION}
  ) else $error("version read data wrong");

  AST_PATTERN_A: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (pin_stable_q[IDX_SOLO] && !pin_stable_q[IDX_SEL]) |=> CH_DRIVE == ~$past(pat_a_q)
  ) else $error("channels not driven from pattern A");

  AST_CH_OFF: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (!pin_stable_q[IDX_SOLO] && !dim_q[0][CH_ON_BIT]) |=> !CH_DRIVE[0]
  ) else $error("disabled channel driven");

endmodule : ldr_regs

/* ldr_regs_bench.sv */
`timescale 1ns/100ps
module ldr_regs_bench;
  import ldr_pkg::*;
  // ----------------------------------------------------------------
  // Settings and signals
  // ----------------------------------------------------------------
  localparam int         FCNT = 4;
  localparam logic [4:0] PTYP = 5'h15; // Arbitrary value
  localparam logic [2:0] PREV = 3'h2;  // Arbitrary value
  localparam logic [7:0] ALIST [10] = '{8'h03, 8'h04, 8'h05, 8'h0A, 8'h10,
                                        8'h20, 8'h21, 8'h22, 8'h24, 8'h30};
  localparam logic [7:0] CLIST [8]  = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0A,
                                        8'h20, 8'h21, 8'h28};
  logic        sys_clk, rst, smode, psel, pgood, rvalid, wack, err, diag;
  logic        wr, rd, seen11;
  logic [7:0]  cmd, addr, wdata, rdata, rc, ra;
  logic [11:0] open_fault, ch_drive, live, pat;
  logic [7:0]  mdl [0:255];
  int          num_errors, samples_checked, seed, k;
  int          gain [12];

  ldr_regs #(.FAULT_CNT(FCNT), .PART_TYPE(PTYP), .REVISION(PREV)) u_ldr_regs (
    .SYS_CLK(sys_clk), .RST(rst), .REG_CMD(cmd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .REG_WACK(wack), .REG_ERR(err),
    .STANDALONE_MODE(smode), .PATTERN_SELECT_PIN(psel), .POWER_GOOD(pgood),
    .OPEN_FAULT(open_fault), .CH_DRIVE(ch_drive), .DIAG_WINDOW(diag));
  ldr_host u_ldr_host (
    .clk(sys_clk), .cmd(cmd), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rvalid(rvalid), .wack(wack), .err(err));

  // Free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Legal command and address pairs
  function automatic logic ok(input logic [7:0] c, a);
    case (a) inside
      8'h03:         return c inside {8'h03, 8'h09, 8'h0A};
      8'h04:         return c inside {8'h09, 8'h0A};
      [8'h05:8'h10]: return c inside {8'h01, 8'h02};
      [8'h20:8'h22]: return c inside {8'h20, 8'h21, 8'h28};
      8'h24:         return c == 8'h28;
      default:       return 1'b0;
    endcase
  endfunction : ok

  // Access through the host, then update the image; reads clear flags
  task automatic acc(input logic w, input logic [7:0] c, a, d, input logic bad);
    logic [7:0] q;
    logic [2:0] ans;
    u_ldr_host.xfer(w, c, a, d, q, ans);
    chk(ans, bad ? 3'b001 : (w ? 3'b010 : 3'b100), "answer");
    if (!w && !bad) chk(q, mdl[a], "read data");
    if (!bad && w && a == 8'h03) mdl[a][7] = d[7];
    if (!bad && w && !(a inside {8'h03, 8'h04, 8'h24})) mdl[a] = d;
    if (!bad && !w && a == 8'h03) mdl[a][3:0] = live[11:8];
    if (!bad && !w && a == 8'h04) mdl[a] = live[7:0];
  endtask : acc

  task automatic sweep();
    for (int a = 0; a < 10; a++) begin
      for (int c = 0; c < 8; c++) begin
        acc(1'b0, CLIST[c], ALIST[a], 8'h00, !ok(CLIST[c], ALIST[a]));
      end
    end
  endtask : sweep

  // Time the gap between falls of two neighbouring channels
  task automatic pwm_gap(input int step);
    logic [11:0] prev;
    logic        done;
    int          n, i, j;
    i = -1;
    prev = ch_drive;
    for (n = 0; n < 20000 && i < 0; n++) begin
      @(negedge sys_clk);
      for (j = 0; j < 11; j++) if (prev[j] && !ch_drive[j]) i = j;
      seen11 |= ch_drive[11];
      prev = ch_drive;
    end
    if (i < 0) begin
      num_errors++;
      tally_and_finish();
    end
    j = (i + 1) % 11;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      done = prev[j] && !ch_drive[j];
      seen11 |= ch_drive[11];
      prev = ch_drive;
    end while (!done && n < 20000);
    chk(n, ((gain[j] - gain[i] + 128) % 128) * step, "step");
    if (!done) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : pwm_gap

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h1A9DC2F3;
    {rst, smode, psel, pgood, seen11} = 5'b10000;
    {open_fault, live} = '0;
    num_errors = 0;
    samples_checked = 0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h24] = {PTYP, PREV};
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    sweep();
    for (k = 0; k < 40; k++) begin
      rc = CLIST[unsigned'($random(seed)) % 8];
      ra = ALIST[unsigned'($random(seed)) % 10];
      acc(1'b1, rc, ra, 8'($random(seed)), !ok(rc, ra));
    end
    acc(1'b1, 8'h03, 8'h03, 8'hFF, 1'b0);
    sweep();
    // Fault outside the window, then inside it
    open_fault = 12'($random(seed)) | 12'h801;
    repeat (30) @(negedge sys_clk);
    chk(diag, 1'b0, "window");
    acc(1'b0, 8'h09, 8'h04, 8'h00, 1'b0);
    pgood = 1'b1;
    repeat (FCNT + 12) @(negedge sys_clk);
    live = open_fault;
    mdl[8'h03][3:0] = live[11:8];
    mdl[8'h04] = live[7:0];
    chk(diag, 1'b1, "window");
    acc(1'b0, 8'h01, 8'h04, 8'h00, 1'b1);
    acc(1'b1, 8'h0A, 8'h04, 8'h00, 1'b0);
    acc(1'b0, 8'h09, 8'h04, 8'h00, 1'b0);
    acc(1'b0, 8'h0A, 8'h03, 8'h00, 1'b0);
    {open_fault, live} = '0;
    repeat (10) @(negedge sys_clk);
    for (k = 0; k < 2; k++) begin
      acc(1'b0, 8'h03, 8'h03, 8'h00, 1'b0);
      acc(1'b0, 8'h0A, 8'h04, 8'h00, 1'b0);
    end
    // Standalone patterns under both selector levels
    smode = 1'b1;
    for (k = 0; k < 3; k++) begin
      ra = 8'(8'h20 + k);
      acc(1'b1, k == 2 ? 8'h28 : ra, ra, 8'($random(seed)), 1'b0);
    end
    for (k = 0; k < 2; k++) begin
      psel = k[0];
      repeat (8) @(negedge sys_clk);
      pat = k ? {mdl[8'h20][7:4], mdl[8'h22]} : {mdl[8'h20][3:0], mdl[8'h21]};
      chk(ch_drive, 12'(~pat), "pattern");
    end
    // Dimming with staggered gains; the last channel stays switched off
    smode = 1'b0;
    for (k = 0; k < 12; k++) begin
      gain[k] = 11 * k + 1;
      acc(1'b1, k[0] ? 8'h02 : 8'h01, 8'(5 + k), {k != 11, 7'(gain[k])}, 1'b0);
    end
    acc(1'b1, 8'h03, 8'h03, 8'h00, 1'b0);
    pwm_gap(STEP_DIV);
    acc(1'b1, 8'h09, 8'h03, 8'h80, 1'b0);
    pwm_gap(STEP_DIV * PRESC_FACTOR);
    chk(seen11, 1'b0, "channel off");
    tally_and_finish();
  end
endmodule : ldr_regs_bench
